// file: psegm_pkg.sv
// Register layout, encodings and carrier types of the general mask block.
package psegm_pkg;

	localparam int          NCH             = 8;
	localparam logic [7:0]  CMD_GENERAL_MASK = 8'h17;
	localparam logic [7:0]  GM_RESET        = 8'h80;
	localparam int          BIT_INT_EN      = 7;
	localparam int          BIT_ACC_WIDTH   = 5;
	localparam int          BIT_PRIO_FMT    = 4;
	localparam int          BIT_CLASS_CHG   = 3;
	localparam int          BIT_DETECT_CHG  = 2;
	localparam logic [3:0]  RESULT_RESET    = 4'h0;
	localparam logic [15:0] LIM_MIN_DEFAULT = 16'h0100;

	// Register access from the serial command decoder.
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] cmd;
		logic [7:0] wdata;
	} psegm_req_t;

	// Per-channel fault strobes.
	typedef struct packed
	{
		logic [NCH-1:0] current_limit_fault;
		logic [NCH-1:0] overload_fault;
		logic [NCH-1:0] signature_dropout_fault;
		logic [NCH-1:0] startup_fault;
	} psegm_fault_t;

	// Per-channel detection and classification completions.
	typedef struct packed
	{
		logic [NCH-1:0]     det_done;
		logic [NCH*4-1:0]   det_result;
		logic [NCH-1:0]     cls_done;
		logic [NCH*4-1:0]   cls_result;
	} psegm_result_t;

	typedef enum logic [2:0]
	{
		LIM_IDLE  = 3'b001,
		LIM_COUNT = 3'b010,
		LIM_FAULT = 3'b100
	} psegm_lim_state_t;

endpackage

// file: psegm_lim_timer.sv
// Per-channel current-limit fault timer; the timeout input is used as given, with no minimum.
`timescale 1ns/1ps
`default_nettype none
module psegm_lim_timer
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        over_limit_i,
	input  wire logic [15:0] limit_fault_timeout_i,
	output logic             fault_o
);
	import psegm_pkg::*;

	psegm_lim_state_t state_q;
	psegm_lim_state_t state_d;
	logic [15:0]      cnt_q;
	logic [15:0]      cnt_d;
	logic             fault_q;
	logic             fault_d;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		fault_d = 1'b0;
		unique case (state_q)
			LIM_IDLE:
			begin
				cnt_d = 16'h0000;
				if (over_limit_i)
					state_d = LIM_COUNT;
			end
			LIM_COUNT:
			begin
				// Counting ends when the count reaches the setting, or earlier if over-limit drops.
				if (!over_limit_i)
					state_d = LIM_IDLE;
				else if (cnt_q >= limit_fault_timeout_i)
				begin
					state_d = LIM_FAULT;
					fault_d = 1'b1;
				end
				else
					cnt_d = cnt_q + 16'h0001;
			end
			LIM_FAULT:
			begin
				if (!over_limit_i)
					state_d = LIM_IDLE;
			end
			default:
				state_d = LIM_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q <= LIM_IDLE;
			cnt_q   <= 16'h0000;
			fault_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			fault_q <= fault_d;
		end
	end

	assign fault_o = fault_q;
endmodule
`default_nettype wire

// file: psegm_top.sv
// General mask register, its effects on interrupt and events, and power status.
`timescale 1ns/1ps
`default_nettype none
module psegm_top
(
	input  wire logic                    mclk_i,
	input  wire logic                    reset_i,
	input  wire psegm_pkg::psegm_req_t   req_i,
	input  wire psegm_pkg::psegm_fault_t fault_i,
	input  wire psegm_pkg::psegm_result_t result_i,
	input  wire logic [7:0]              over_limit_i,
	input  wire logic [15:0]             limit_fault_timeout_i,
	input  wire logic [7:0]              power_on_i,
	input  wire logic [7:0]              int_pending_i,
	input  wire logic [7:0]              event_clear_i,
	output logic [7:0]                   rdata_o,
	output logic                         rvalid_o,
	output logic [7:0]                   general_mask_o,
	output logic                         interrupt_o,
	output logic                         access_16bit_o,
	output logic                         priority_3bit_o,
	output logic [7:0]                   power_good_flag_o,
	output logic [7:0]                   power_enable_flag_o,
	output logic [7:0]                   class_event_flag_o,
	output logic [7:0]                   detect_event_flag_o
);
	import psegm_pkg::*;

	logic [7:0]     gm_q;
	logic [7:0]     gm_d;
	logic [7:0]     rdata_q;
	logic [7:0]     rdata_d;
	logic           rvalid_q;
	logic           rvalid_d;
	logic           irq_q;
	logic           irq_d;
	logic [NCH-1:0] pg_q;
	logic [NCH-1:0] pg_d;
	logic [NCH-1:0] pe_q;
	logic [NCH-1:0] pe_d;
	logic [NCH-1:0] cls_q;
	logic [NCH-1:0] cls_d;
	logic [NCH-1:0] det_q;
	logic [NCH-1:0] det_d;
	logic [NCH*4-1:0] cls_last_q;
	logic [NCH*4-1:0] cls_last_d;
	logic [NCH*4-1:0] det_last_q;
	logic [NCH*4-1:0] det_last_d;
	logic [NCH-1:0] lim_fault;
	logic [NCH-1:0] any_fault;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	// A completed cycle raises its flag, unless change-only is on and
	// the result repeats the previous one.
	function automatic logic event_hit(input logic done, input logic chg_only,
		input logic [3:0] now, input logic [3:0] last);
		event_hit = done && (!chg_only || (now != last));
	endfunction

	// Only the general mask command is decoded; other codes fall through.
	function automatic logic cmd_hit(input logic strobe,
		input logic [7:0] cmd);
		cmd_hit = strobe && (cmd == CMD_GENERAL_MASK);
	endfunction

	// Four-bit result field of one channel.
	function automatic logic [3:0] nibble(input logic [NCH*4-1:0] vec,
		input int ch);
		nibble = vec[ch*4 +: 4];
	endfunction

	// --------------------------------------------------------------
	// Current-limit timers
	// --------------------------------------------------------------
	// One timer per channel; all channels share one timeout setting.
	for (genvar g = 0; g < NCH; g++)
	begin : g_lim
		psegm_lim_timer u_lim
		(
			.mclk_i                (mclk_i),
			.reset_i               (reset_i),
			.over_limit_i          (over_limit_i[g]),
			.limit_fault_timeout_i (limit_fault_timeout_i),
			.fault_o               (lim_fault[g])
		);
	end

	assign any_fault = lim_fault | fault_i.current_limit_fault
		| fault_i.overload_fault | fault_i.signature_dropout_fault
		| fault_i.startup_fault;

	// --------------------------------------------------------------
	// Register access
	// --------------------------------------------------------------
	always_comb
	begin
		gm_d     = gm_q;
		rdata_d  = rdata_q;
		rvalid_d = 1'b0;
		// Unused bits are stored too, so a read returns what was written.
		if (cmd_hit(req_i.wr, req_i.cmd))
			gm_d = req_i.wdata;
		if (cmd_hit(req_i.rd, req_i.cmd))
		begin
			rdata_d  = gm_q;
			rvalid_d = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			gm_q     <= GM_RESET;
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end
		else
		begin
			gm_q     <= gm_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// --------------------------------------------------------------
	// Interrupt gate
	// --------------------------------------------------------------
	always_comb
	begin
		// Gated before the flop, so the pin cannot pulse once enable has been low for a cycle.
		irq_d = gm_q[BIT_INT_EN] && (|int_pending_i);
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end

	// --------------------------------------------------------------
	// Power status and events
	// --------------------------------------------------------------
	always_comb
	begin
		pg_d       = pg_q;
		pe_d       = pe_q;
		cls_d      = cls_q & ~event_clear_i;
		det_d      = det_q & ~event_clear_i;
		cls_last_d = cls_last_q;
		det_last_d = det_last_q;
		for (int i = 0; i < NCH; i++)
		begin
			if (any_fault[i])
			begin
				// Fault wins over a port turning on in the same cycle.
				pg_d[i] = 1'b0;
				pe_d[i] = 1'b0;
			end
			else
			begin
				pg_d[i] = power_on_i[i];
				pe_d[i] = power_on_i[i] | pe_q[i];
			end
			// Events ignore the interrupt enable; set wins over clear.
			if (event_hit(result_i.cls_done[i], gm_q[BIT_CLASS_CHG],
				nibble(result_i.cls_result, i), nibble(cls_last_q, i)))
				cls_d[i] = 1'b1;
			if (event_hit(result_i.det_done[i], gm_q[BIT_DETECT_CHG],
				nibble(result_i.det_result, i), nibble(det_last_q, i)))
				det_d[i] = 1'b1;
			if (result_i.cls_done[i])
				cls_last_d[i*4 +: 4] = result_i.cls_result[i*4 +: 4];
			if (result_i.det_done[i])
				det_last_d[i*4 +: 4] = result_i.det_result[i*4 +: 4];
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pg_q       <= '0;
			pe_q       <= '0;
			cls_q      <= '0;
			det_q      <= '0;
			cls_last_q <= {NCH{RESULT_RESET}};
			det_last_q <= {NCH{RESULT_RESET}};
		end
		else
		begin
			pg_q       <= pg_d;
			pe_q       <= pe_d;
			cls_q      <= cls_d;
			det_q      <= det_d;
			cls_last_q <= cls_last_d;
			det_last_q <= det_last_d;
		end
	end

	assign rdata_o             = rdata_q;
	assign rvalid_o            = rvalid_q;
	assign general_mask_o      = gm_q;
	assign interrupt_o         = irq_q;
	assign access_16bit_o      = gm_q[BIT_ACC_WIDTH];
	assign priority_3bit_o     = gm_q[BIT_PRIO_FMT];
	assign power_good_flag_o   = pg_q;
	assign power_enable_flag_o = pe_q;
	assign class_event_flag_o  = cls_q;
	assign detect_event_flag_o = det_q;
endmodule
`default_nettype wire

// file: psegm_chk.sv
// Checker of the general mask block, seeing only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module psegm_chk
	import psegm_pkg::*;
(
	input  wire logic                    mclk_i,
	input  wire logic                    reset_i,
	input  wire psegm_pkg::psegm_req_t   req_i,
	input  wire psegm_pkg::psegm_fault_t fault_i,
	input  wire psegm_pkg::psegm_result_t result_i,
	input  wire logic [7:0]              int_pending_i,
	input  wire logic [7:0]              rdata_o,
	input  wire logic                    rvalid_o,
	input  wire logic [7:0]              general_mask_o,
	input  wire logic                    interrupt_o,
	input  wire logic                    access_16bit_o,
	input  wire logic                    priority_3bit_o,
	input  wire logic [7:0]              power_good_flag_o,
	input  wire logic [7:0]              power_enable_flag_o,
	input  wire logic [7:0]              detect_event_flag_o
);
	logic [7:0] f_any;
	logic       rd_hit;
	logic       wr_hit;
	assign f_any = fault_i.current_limit_fault | fault_i.overload_fault
		| fault_i.signature_dropout_fault | fault_i.startup_fault;
	assign rd_hit = req_i.rd && (req_i.cmd == CMD_GENERAL_MASK);
	assign wr_hit = req_i.wr && (req_i.cmd == CMD_GENERAL_MASK);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	property p_wr; wr_hit |=> general_mask_o == $past(req_i.wdata); endproperty
	a_wr: assert property (p_wr) else $error("write not stored");
	property p_rd; rd_hit |=> rvalid_o && rdata_o == $past(general_mask_o);
	endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");
	property p_ref; !rd_hit |=> !rvalid_o; endproperty
	a_ref: assert property (p_ref) else $error("stray read valid");
	property p_flt; (f_any != 8'h00) |=>
		((power_good_flag_o | power_enable_flag_o) & $past(f_any)) == 8'h00;
	endproperty
	a_flt: assert property (p_flt) else $error("fault left power on");
	property p_ioff; !general_mask_o[BIT_INT_EN] |=> !interrupt_o; endproperty
	a_ioff: assert property (p_ioff) else $error("masked interrupt");
	property p_ion; general_mask_o[BIT_INT_EN] && (int_pending_i != 8'h00)
		|=> interrupt_o; endproperty
	a_ion: assert property (p_ion) else $error("interrupt missing");
	property p_acc; $stable(general_mask_o) |->
		access_16bit_o == general_mask_o[BIT_ACC_WIDTH]; endproperty
	a_acc: assert property (p_acc) else $error("width select wrong");
	property p_pri; $stable(general_mask_o) |->
		priority_3bit_o == general_mask_o[BIT_PRIO_FMT]; endproperty
	a_pri: assert property (p_pri) else $error("priority select wrong");
	property p_det; result_i.det_done[0] && !general_mask_o[BIT_DETECT_CHG]
		|=> detect_event_flag_o[0]; endproperty
	a_det: assert property (p_det) else $error("detect flag missing");
endmodule
bind psegm_top psegm_chk psegm_chk_inst (.mclk_i, .reset_i, .req_i, .fault_i,
	.result_i, .int_pending_i, .rdata_o, .rvalid_o, .general_mask_o,
	.interrupt_o, .access_16bit_o, .priority_3bit_o, .power_good_flag_o,
	.power_enable_flag_o, .detect_event_flag_o);
`default_nettype wire

// file: psegm_host.sv
// Host model issuing single-byte register commands.
`timescale 1ns/1ps
`default_nettype none
module psegm_host
	import psegm_pkg::*;
(
	input  wire logic             mclk_i,
	input  wire logic             rvalid_i,
	input  wire logic [7:0]       rdata_i,
	output var psegm_pkg::psegm_req_t req_o
);
	initial req_o = '0;
	// One command code and one data byte per transfer.
	task automatic xfer(input logic w, input logic r, input logic [7:0] c,
		input logic [7:0] d, output logic v, output logic [7:0] q);
		@(posedge mclk_i);
		#1 req_o = '{wr: w, rd: r, cmd: c, wdata: d};
		@(posedge mclk_i);
		#1 v = rvalid_i;
		q = rdata_i;
		// Released lines show a changed value, not the last one.
		req_o = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~d};
	endtask
endmodule
`default_nettype wire

// file: tb_psegm_top.sv
// Self-checking testbench of the general mask block.
`timescale 1ns/1ps
`default_nettype none
module tb_psegm_top;
	import psegm_pkg::*;
	logic mclk_i, reset_i, rvalid_o, interrupt_o, acc, pri, v;
	psegm_req_t req;
	psegm_fault_t flt;
	psegm_result_t res;
	logic [7:0] ol, pon, ipend, eclr, rdata, gm, pg, pe, cls, det, q;
	logic [15:0] lft;
	int miscompares, comparisons;
	psegm_top psegm_top_inst (.mclk_i, .reset_i, .req_i(req), .fault_i(flt),
		.result_i(res), .over_limit_i(ol), .limit_fault_timeout_i(lft),
		.power_on_i(pon), .int_pending_i(ipend), .event_clear_i(eclr),
		.rdata_o(rdata), .rvalid_o, .general_mask_o(gm), .interrupt_o,
		.access_16bit_o(acc), .priority_3bit_o(pri), .power_good_flag_o(pg),
		.power_enable_flag_o(pe), .class_event_flag_o(cls),
		.detect_event_flag_o(det));
	psegm_host psegm_host_inst (.mclk_i, .rvalid_i(rvalid_o),
		.rdata_i(rdata), .req_o(req));
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		psegm_host_inst.xfer(1'b1, 1'b0, c, d, v, q);
	endtask
	task automatic rd(input logic [7:0] c);
		psegm_host_inst.xfer(1'b0, 1'b1, c, 8'h00, v, q);
	endtask
	task automatic t_reg();
		rd(CMD_GENERAL_MASK);
		chk(8'(v), 8'h01);
		chk(q, GM_RESET);
		chk({6'h00, acc, pri}, 8'h00);
		wr(CMD_GENERAL_MASK, 8'hff);
		rd(CMD_GENERAL_MASK);
		chk(q, 8'hff);
		chk({6'h00, acc, pri}, 8'h03);
		wr(8'h18, 8'h00);
		rd(8'h18);
		chk(8'(v), 8'h00);
		chk(gm, 8'hff);
		wr(CMD_GENERAL_MASK, 8'h00);
		rd(CMD_GENERAL_MASK);
		chk(q, 8'h00);
	endtask
	task automatic t_int();
		ipend = 8'h01;
		step(2);
		chk(8'(interrupt_o), 8'h00);
		wr(CMD_GENERAL_MASK, GM_RESET);
		step(1);
		chk(8'(interrupt_o), 8'h01);
		ipend = 8'h00;
	endtask
	task automatic t_flt();
		pon = 8'hff;
		step(3);
		chk(pe, 8'hff);
		for (int k = 0; k < 4; k++)
		begin
			flt = 32'h1 << (k * 9);
			step(1);
			flt = '0;
			chk(8'((pg[k] | pe[k])), 8'h00);
		end
		chk(pe, 8'hf7);
	endtask
	task automatic t_lim();
		int i;
		lft = 16'h0004;
		ol = 8'h10;
		step(6);
		chk(8'(pg[4]), 8'h01);
		for (i = 0; i < 20 && pg[4] !== 1'b0; i++)
			step(1);
		chk(8'(i < 20), 8'h01);
		ol = 8'h00;
		if (i >= 20)
			close_out();
	endtask
	task automatic t_evt(input logic [3:0] r, input logic [7:0] e);
		res.det_result = {28'h0, r};
		res.cls_result = {28'h0, r};
		res.det_done = 8'h01;
		res.cls_done = 8'h01;
		step(1);
		res.det_done = 8'h00;
		res.cls_done = 8'h00;
		chk({6'h00, cls[0], det[0]}, e);
		eclr = 8'h01;
		step(1);
		eclr = 8'h00;
	endtask
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		reset_i = 1'b1;
		{flt, res, ol, lft, pon, ipend, eclr} = '0;
		step(4);
		reset_i = 1'b0;
		t_reg();
		t_int();
		t_flt();
		t_lim();
		wr(CMD_GENERAL_MASK, 8'h0c);
		t_evt(4'h0, 8'h00);
		t_evt(4'h3, 8'h03);
		t_evt(4'h3, 8'h00);
		// A repeated result still records once change-only detection is off.
		wr(CMD_GENERAL_MASK, 8'h00);
		t_evt(4'h3, 8'h03);
		close_out();
	end
endmodule
`default_nettype wire
